//--- design/addr_mode_pkg.sv
// Package: addressing modes, operations and shared constants
package addr_mode_pkg;

  localparam int INSTR_COUNT = 62;
  localparam int MODE_COUNT = 8;
  localparam logic [7:0] ZERO_PAGE_HIGH = 8'h00;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_ACC = 8'h00;
  localparam logic [7:0] RESET_INDEX = 8'h00;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  typedef enum logic [2:0] {
    MODE_INH = 3'h0,
    MODE_IMM = 3'h1,
    MODE_DIR = 3'h2,
    MODE_EXT = 3'h3,
    MODE_IX = 3'h4,
    MODE_IX1 = 3'h5,
    MODE_IX2 = 3'h6,
    MODE_REL = 3'h7
  } addr_mode_t;

  typedef enum logic [3:0] {
    OP_ADC = 4'h0,
    OP_ADD = 4'h1,
    OP_AND = 4'h2,
    OP_BIT = 4'h3,
    OP_COMPARE_ACC = 4'h4,
    OP_COMPARE_INDEX = 4'h5,
    OP_XOR_ACC = 4'h6,
    OP_LOAD_ACC = 4'h7,
    OP_LOAD_INDEX = 4'h8,
    OP_UNSIGNED_MULTIPLY = 4'h9,
    OP_OR_ACC = 4'hA,
    OP_SUB_WITH_CARRY = 4'hB,
    OP_STORE_ACC = 4'hC,
    OP_STORE_INDEX = 4'hD,
    OP_SUB = 4'hE,
    OP_BRANCH = 4'hF
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPER1 = 3'h1,
    ST_OPER2 = 3'h3,
    ST_MEMRD = 3'h2,
    ST_EXEC = 3'h6
  } seq_state_t;

  // One instruction as handed in by the core
  typedef struct packed {
    addr_mode_t mode;
    op_t op;
    logic bitTest;
    logic [2:0] bitSel;
    logic bitWhenSet;
    logic condTrue;
  } instr_t;

  // Memory bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  function automatic logic [1:0] modeLength(input addr_mode_t m);
    case (m)
      MODE_INH, MODE_IX: modeLength = LEN_ONE;
      MODE_EXT, MODE_IX2: modeLength = LEN_THREE;
      default: modeLength = LEN_TWO;
    endcase
  endfunction

endpackage

//--- design/ea_calc.sv
// Effective address and branch target arithmetic
`timescale 1ns/1ps
`default_nettype none
module ea_calc
  import addr_mode_pkg::*;
(
  input wire addr_mode_t mode,
  input wire logic [7:0] index,
  input wire logic [7:0] oper1,
  input wire logic [7:0] oper2,
  input wire logic [15:0] nextPc,
  output logic [15:0] effAddr,
  output logic [15:0] branchTarget
);
  wire [15:0] ix1Sum = {8'h00, index} + {8'h00, oper1};
  wire [15:0] ix2Sum = {oper1, oper2} + {8'h00, index};
  wire [15:0] relOff = {{8{oper1[7]}}, oper1};

  // Signed reach -128..+127 from next instruction
  assign branchTarget = nextPc + relOff;

  always_comb begin
    case (mode)
      MODE_DIR: effAddr = {ZERO_PAGE_HIGH, oper1};
      MODE_EXT: effAddr = {oper1, oper2};
      MODE_IX: effAddr = {ZERO_PAGE_HIGH, index};
      MODE_IX1: effAddr = ix1Sum;
      MODE_IX2: effAddr = ix2Sum;
      default: effAddr = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

//--- design/byte_multiplier.sv
// Unsigned 8x8 multiplier with registered product
`timescale 1ns/1ps
`default_nettype none
module byte_multiplier (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] acc,
  input wire logic [7:0] index,
  output logic [15:0] product
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      product <= 16'h0000;
    end else begin
      product <= {8'h00, acc} * {8'h00, index};
    end
  end
endmodule
`default_nettype wire

//--- design/cpu_address_mode_decoder.sv
// Operand fetch, address generation and register/memory execution
// Behaviour
// - 62 instructions, eight addressing modes, plus unsigned multiply.
// - Multiply acc by index unsigned; high byte to index, low to acc.
// - Inherent: one byte, no operand address.
// - Immediate: two bytes, data byte used directly, no memory fetch.
// - Direct: two bytes, address high byte zero.
// - Extended: three bytes, high address byte first.
// - Indexed no offset: one byte, address is zero-page index.
// - Indexed 8-bit offset: two bytes, index plus byte, carry kept.
// - Indexed 16-bit offset: three bytes, index plus high-first offset.
// - Relative only for branches; taken adds signed byte, else next.
// - Offset is two's complement, measured from next instruction.
// - Register/memory: one operand from register, other from memory.
// - Group covers add, logic, compare, load, store, multiply, subtract.
// - Bit-test branch: three bytes; tested bit goes to carry always.
`timescale 1ns/1ps
`default_nettype none
module cpu_address_mode_decoder
  import addr_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire instr_t instr,
  input wire logic [7:0] memRdata,
  input wire logic carryIn,
  output mem_req_t memReq,
  output logic [15:0] pc,
  output logic [7:0] acc,
  output logic [7:0] index,
  output logic carryOut,
  output logic [1:0] instrLen,
  output logic done
);

  // ==========================================================
  // State
  seq_state_t state_reg, state_next;
  instr_t instr_reg;
  logic [7:0] oper1_reg, oper2_reg, memData_reg;
  logic [15:0] pc_reg;
  logic [7:0] acc_reg, index_reg;
  logic carry_reg;
  logic [1:0] len_reg;
  logic done_reg;
  logic mulPending_reg;
  mem_req_t req_reg, req_next;

  wire [15:0] effAddr;
  wire [15:0] branchTarget;
  wire [15:0] product;
  wire [1:0] lenNow;
  wire isBitBranch;
  wire [1:0] needOpers;
  wire needsMem;
  wire isStore;
  wire [15:0] nextPc;
  wire testedBit;
  wire branchTaken;

  // ==========================================================
  // Decode
  assign isBitBranch = instr_reg.bitTest;
  assign lenNow = isBitBranch ? LEN_THREE : modeLength(instr_reg.mode);
  assign needOpers = lenNow - 2'h1;
  assign isStore = instr_reg.op == OP_STORE_ACC ||
                   instr_reg.op == OP_STORE_INDEX;
  // Immediate and inherent never take a data memory access
  assign needsMem = isBitBranch ||
                    (instr_reg.mode != MODE_INH &&
                     instr_reg.mode != MODE_IMM &&
                     instr_reg.mode != MODE_REL &&
                     instr_reg.op != OP_UNSIGNED_MULTIPLY);
  // PC past all operand bytes before offset add
  assign nextPc = pc_reg + {14'h0000, lenNow};
  assign testedBit = memData_reg[instr_reg.bitSel];
  assign branchTaken = isBitBranch ?
                       (testedBit == instr_reg.bitWhenSet) :
                       instr_reg.condTrue;

  ea_calc eaCalc (
    .mode(addr_mode_t'(isBitBranch ? MODE_DIR : instr_reg.mode)),
    .index(index_reg),
    .oper1(oper1_reg),
    .oper2(oper2_reg),
    .nextPc(nextPc),
    .effAddr(effAddr),
    .branchTarget()
  );

  ea_calc relCalc (
    .mode(MODE_REL),
    .index(index_reg),
    .oper1(isBitBranch ? oper2_reg : oper1_reg),
    .oper2(oper2_reg),
    .nextPc(nextPc),
    .effAddr(),
    .branchTarget(branchTarget)
  );

  byte_multiplier mult (
    .clk(clk),
    .rst_n(rst_n),
    .acc(acc_reg),
    .index(index_reg),
    .product(product)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    req_next = '0;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_OPER1;
        end
      end
      ST_OPER1: begin
        // One-byte indexed still needs its operand fetch
        if (needOpers == 2'h0 && needsMem) begin
          state_next = ST_MEMRD;
        end else if (needOpers == 2'h0) begin
          state_next = ST_EXEC;
        end else begin
          req_next.rd = 1'b1;
          req_next.addr = pc_reg + 16'h0001;
          state_next = ST_OPER2;
        end
      end
      ST_OPER2: begin
        if (needOpers == 2'h2 && !req_reg.addr[0] == pc_reg[0]) begin
          req_next.rd = 1'b1;
          req_next.addr = pc_reg + 16'h0002;
          state_next = ST_OPER2;
        end else if (needsMem) begin
          state_next = ST_MEMRD;
        end else begin
          state_next = ST_EXEC;
        end
      end
      ST_MEMRD: begin
        req_next.rd = !isStore;
        req_next.wr = isStore;
        req_next.addr = effAddr;
        req_next.wdata = instr_reg.op == OP_STORE_INDEX ?
                         index_reg : acc_reg;
        state_next = ST_EXEC;
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Operand capture
  wire capture1 = state_reg == ST_OPER2 && req_reg.addr == pc_reg + 16'h0001;
  wire capture2 = state_reg == ST_OPER2 && req_reg.addr == pc_reg + 16'h0002;
  wire captureMem = state_reg == ST_EXEC && req_reg.rd;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      instr_reg <= '0;
      oper1_reg <= 8'h00;
      oper2_reg <= 8'h00;
      memData_reg <= 8'h00;
      req_reg <= '0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      if (state_reg == ST_IDLE && start) begin
        instr_reg <= instr;
      end
      if (capture1) begin
        oper1_reg <= memRdata;
      end
      if (capture2) begin
        oper2_reg <= memRdata;
      end
      if (captureMem) begin
        memData_reg <= memRdata;
      end
    end
  end

  // ==========================================================
  // Execute
  wire [7:0] operand = captureMem ? memRdata : oper1_reg;
  wire [8:0] addSum = {1'b0, acc_reg} + {1'b0, operand};
  wire [8:0] addCSum = addSum + {8'h00, carry_reg};
  wire [8:0] subDiff = {1'b0, acc_reg} - {1'b0, operand};
  wire [8:0] subCDiff = subDiff - {8'h00, carry_reg};
  wire [8:0] cpxDiff = {1'b0, index_reg} - {1'b0, operand};
  wire [7:0] bitOperand = captureMem ? memRdata : memData_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= RESET_PC;
      acc_reg <= RESET_ACC;
      index_reg <= RESET_INDEX;
      carry_reg <= 1'b0;
      len_reg <= LEN_ONE;
      done_reg <= 1'b0;
      mulPending_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (state_reg == ST_IDLE && start) begin
        carry_reg <= carryIn;
      end
      if (mulPending_reg) begin
        index_reg <= product[15:8];
        acc_reg <= product[7:0];
        mulPending_reg <= 1'b0;
      end
      if (state_reg == ST_EXEC) begin
        done_reg <= 1'b1;
        len_reg <= lenNow;
        if (isBitBranch) begin
          carry_reg <= bitOperand[instr_reg.bitSel];
          pc_reg <= (bitOperand[instr_reg.bitSel] == instr_reg.bitWhenSet)
                    ? branchTarget : nextPc;
        end else if (instr_reg.mode == MODE_REL) begin
          pc_reg <= branchTaken ? branchTarget : nextPc;
        end else begin
          pc_reg <= nextPc;
          case (instr_reg.op)
            OP_ADC: begin
              acc_reg <= addCSum[7:0];
              carry_reg <= addCSum[8];
            end
            OP_ADD: begin
              acc_reg <= addSum[7:0];
              carry_reg <= addSum[8];
            end
            OP_AND: acc_reg <= acc_reg & operand;
            OP_COMPARE_ACC: carry_reg <= subDiff[8];
            OP_COMPARE_INDEX: carry_reg <= cpxDiff[8];
            OP_XOR_ACC: acc_reg <= acc_reg ^ operand;
            OP_LOAD_ACC: acc_reg <= operand;
            OP_LOAD_INDEX: index_reg <= operand;
            OP_UNSIGNED_MULTIPLY: mulPending_reg <= 1'b1;
            OP_OR_ACC: acc_reg <= acc_reg | operand;
            OP_SUB_WITH_CARRY: begin
              acc_reg <= subCDiff[7:0];
              carry_reg <= subCDiff[8];
            end
            OP_SUB: begin
              acc_reg <= subDiff[7:0];
              carry_reg <= subDiff[8];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  assign memReq = req_reg;
  assign pc = pc_reg;
  assign acc = acc_reg;
  assign index = index_reg;
  assign carryOut = carry_reg;
  assign instrLen = len_reg;
  assign done = done_reg;

  // ==========================================================
  // Checks
  direct_page_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_MEMRD && !isBitBranch && instr_reg.mode == MODE_DIR)
    |=> memReq.addr[15:8] == 8'h00)
    else $error("direct address high byte not zero");
  index_page_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_MEMRD && instr_reg.mode == MODE_IX && !isBitBranch)
    |=> memReq.addr == {8'h00, $past(index_reg)})
    else $error("indexed address wrong");
  ix1_span_a: assert property (@(posedge clk) disable iff (!rst_n)
    memReq.rd && $past(state_reg) == ST_MEMRD &&
    $past(instr_reg.mode) == MODE_IX1 |-> memReq.addr <= 16'h01FE)
    else $error("8-bit offset address out of span");
  len_report_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_EXEC |=> done && instrLen == $past(lenNow))
    else $error("length not reported");
  imm_nofetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_EXEC && instr_reg.mode == MODE_IMM && !isBitBranch
    |-> !memReq.rd && !memReq.wr)
    else $error("memory fetch in immediate mode");
  inh_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    done && $past(instr_reg.mode, 2) == MODE_INH && !$past(isBitBranch, 2)
    |-> instrLen == 2'h1)
    else $error("inherent length not one");
  mul_result_a: assert property (@(posedge clk) disable iff (!rst_n)
    mulPending_reg |=> {index, acc} == $past(product))
    else $error("multiply result misplaced");
  branch_pc_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_EXEC && instr_reg.mode == MODE_REL && !isBitBranch &&
    !instr_reg.condTrue |=> pc == $past(pc_reg) + 16'h0002)
    else $error("untaken branch did not fall through");
  bit_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_EXEC && isBitBranch
    |=> carryOut == $past(bitOperand[instr_reg.bitSel]))
    else $error("tested bit not copied to carry");
endmodule
`default_nettype wire

//--- bench/cpu_bus_memory.sv
// Program and data memory model on the CPU bus
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_memory
  import addr_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire mem_req_t memReq,
  output logic [7:0] memRdata
);
  // ==========================================================
  // Storage and read hold
  logic [7:0] mem [0:65535];
  logic [7:0] heldData_reg;
  logic hold_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      heldData_reg <= 8'h00;
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= memReq.rd;
      if (memReq.rd) begin
        heldData_reg <= mem[memReq.addr];
      end else if (!hold_reg) begin
        heldData_reg <= ~heldData_reg;
      end
      if (memReq.wr) begin
        mem[memReq.addr] <= memReq.wdata;
      end
    end
  end

  // Data valid in the read cycle and the one after, then scrambled
  assign memRdata = memReq.rd ? mem[memReq.addr] :
                    (hold_reg ? heldData_reg : ~heldData_reg);
endmodule
`default_nettype wire

//--- bench/cpu_address_mode_decoder_tb.sv
// Self-checking testbench for the address mode decoder
`timescale 1ns/1ps
`default_nettype none
module cpu_address_mode_decoder_tb
  import addr_mode_pkg::*;
;
  // ==========================================================
  // Signals and instances
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic carryIn = 1'b0;
  instr_t instr = '0;
  wire logic [7:0] memRdata;
  mem_req_t memReq;
  logic [15:0] pc;
  logic [7:0] acc;
  logic [7:0] index;
  logic carryOut;
  logic done;
  logic [1:0] instrLen;
  int num_errors = 0;
  int comparisons = 0;
  int rdCount = 0;
  int rdBase = 0;
  logic [15:0] lastRd = '0;
  logic [15:0] pcExp = '0;

  cpu_address_mode_decoder u_cpu_address_mode_decoder (.clk(clk),
    .rst_n(rst_n), .start(start), .instr(instr), .memRdata(memRdata),
    .carryIn(carryIn), .memReq(memReq), .pc(pc), .acc(acc),
    .index(index), .carryOut(carryOut), .instrLen(instrLen), .done(done));
  cpu_bus_memory u_cpu_bus_memory (.clk(clk), .rst_n(rst_n),
    .memReq(memReq), .memRdata(memRdata));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    if (memReq.rd === 1'b1) begin
      rdCount <= rdCount + 1;
      lastRd <= memReq.addr;
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic summarize();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk16(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic instr_t mk(input addr_mode_t m, input op_t o);
    mk = '0;
    mk.mode = m;
    mk.op = o;
  endfunction

  // Operand bytes follow the opcode at pc
  task automatic exec(input instr_t i, input logic [7:0] b1,
                      input logic [7:0] b2, input logic [1:0] len,
                      input logic [15:0] nextPc);
    int n;
    u_cpu_bus_memory.mem[pcExp + 16'h1] = b1;
    u_cpu_bus_memory.mem[pcExp + 16'h2] = b2;
    @(negedge clk);
    rdBase = rdCount;
    start = 1'b1;
    instr = i;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      num_errors++;
      $display("[FAIL] done expected 1 seen %b", done);
      summarize();
    end
    @(negedge clk);
    chk8("instrLen", {6'h0, len}, {6'h0, instrLen});
    chk16("pc", nextPc, pc);
    pcExp = nextPc;
  endtask

  // ==========================================================
  // Scenarios
  task automatic testImmediate();
    exec(mk(MODE_IMM, OP_LOAD_INDEX), 8'hF0, 8'h00, LEN_TWO, pcExp + 16'h2);
    chk8("immReads", 8'h01, 8'(rdCount - rdBase));
    chk8("index", 8'hF0, index);
  endtask

  task automatic testAddrModes();
    addr_mode_t m [5] = '{MODE_DIR, MODE_EXT, MODE_IX, MODE_IX1, MODE_IX2};
    logic [7:0] b1 [5] = '{8'h80, 8'h34, 8'h00, 8'hFF, 8'h12};
    logic [7:0] b2 [5] = '{8'h00, 8'h56, 8'h00, 8'h00, 8'hFF};
    logic [15:0] ea [5] = '{16'h0080, 16'h3456, 16'h00F0, 16'h01EF,
                            16'h13EF};
    logic [1:0] ln [5] = '{LEN_TWO, LEN_THREE, LEN_ONE, LEN_TWO, LEN_THREE};
    for (int k = 0; k < 5; k++) begin
      u_cpu_bus_memory.mem[ea[k]] = 8'hC0 + 8'(k);
      exec(mk(m[k], OP_LOAD_ACC), b1[k], b2[k], ln[k],
           pcExp + 16'(ln[k]));
      chk16("operandAddr", ea[k], lastRd);
      chk8("acc", 8'hC0 + 8'(k), acc);
    end
  endtask

  task automatic testAluGroup();
    op_t ops [11] = '{OP_ADC, OP_ADD, OP_AND, OP_BIT, OP_COMPARE_ACC,
      OP_COMPARE_INDEX, OP_XOR_ACC, OP_OR_ACC, OP_SUB_WITH_CARRY, OP_SUB,
      OP_LOAD_ACC};
    logic [7:0] ex [11] = '{8'hE2, 8'hE1, 8'h24, 8'h3C, 8'h3C, 8'h3C,
      8'h99, 8'hBD, 8'h96, 8'h97, 8'hA5};
    // Carry after each op; compares borrow, logic ops keep carry in
    logic cy [11] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1,
      1'b1, 1'b1, 1'b1};
    carryIn = 1'b1;
    for (int k = 0; k < 11; k++) begin
      exec(mk(MODE_IMM, OP_LOAD_ACC), 8'h3C, 8'h00, LEN_TWO, pcExp + 16'h2);
      exec(mk(MODE_IMM, ops[k]), 8'hA5, 8'h00, LEN_TWO, pcExp + 16'h2);
      chk8("aluAcc", ex[k], acc);
      chk8("aluIndex", 8'hF0, index);
      chk8("aluCarry", {7'h00, cy[k]}, {7'h00, carryOut});
    end
    carryIn = 1'b0;
  endtask

  task automatic testStore();
    exec(mk(MODE_EXT, OP_STORE_ACC), 8'h23, 8'h45, LEN_THREE, pcExp + 16'h3);
    chk8("storedAcc", 8'hA5, u_cpu_bus_memory.mem[16'h2345]);
    exec(mk(MODE_DIR, OP_STORE_INDEX), 8'h90, 8'h00, LEN_TWO, pcExp + 16'h2);
    chk8("storedIndex", 8'hF0, u_cpu_bus_memory.mem[16'h0090]);
  endtask

  task automatic testMultiply();
    exec(mk(MODE_IMM, OP_LOAD_ACC), 8'hFE, 8'h00, LEN_TWO, pcExp + 16'h2);
    exec(mk(MODE_IMM, OP_LOAD_INDEX), 8'hFD, 8'h00, LEN_TWO, pcExp + 16'h2);
    exec(mk(MODE_INH, OP_UNSIGNED_MULTIPLY), 8'h00, 8'h00, LEN_ONE,
         pcExp + 16'h1);
    chk8("inhReads", 8'h00, 8'(rdCount - rdBase));
    chk8("productHigh", 8'hFB, index);
    chk8("productLow", 8'h06, acc);
  endtask

  task automatic testBranch();
    instr_t b;
    b = mk(MODE_REL, OP_BRANCH);
    b.condTrue = 1'b1;
    exec(b, 8'h80, 8'h00, LEN_TWO, pcExp + 16'h2 - 16'h80);
    exec(b, 8'h7F, 8'h00, LEN_TWO, pcExp + 16'h2 + 16'h7F);
    b.condTrue = 1'b0;
    exec(b, 8'h7F, 8'h00, LEN_TWO, pcExp + 16'h2);
  endtask

  task automatic testBitBranch();
    instr_t b;
    b = mk(MODE_REL, OP_BRANCH);
    b.bitTest = 1'b1;
    b.bitSel = 3'h3;
    b.bitWhenSet = 1'b1;
    b.condTrue = 1'b1;
    u_cpu_bus_memory.mem[16'h0040] = 8'h08;
    exec(b, 8'h40, 8'hF0, LEN_THREE, pcExp + 16'h3 - 16'h10);
    chk16("testedAddr", 16'h0040, lastRd);
    chk8("carrySet", 8'h01, {7'h0, carryOut});
    b.bitWhenSet = 1'b0;
    b.condTrue = 1'b0;
    exec(b, 8'h40, 8'h10, LEN_THREE, pcExp + 16'h3);
    chk8("carryNotTaken", 8'h01, {7'h0, carryOut});
    b.bitSel = 3'h2;
    b.condTrue = 1'b1;
    exec(b, 8'h40, 8'h10, LEN_THREE, pcExp + 16'h13);
    chk8("carryClear", 8'h00, {7'h0, carryOut});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk16("resetPc", RESET_PC, pc);
    chk8("resetAcc", RESET_ACC, acc);
    chk8("resetIndex", RESET_INDEX, index);
    chk8("resetLen", {6'h0, LEN_ONE}, {6'h0, instrLen});
    testImmediate();
    testAddrModes();
    testAluGroup();
    testStore();
    testMultiply();
    testBranch();
    testBitBranch();
    summarize();
  end
endmodule
`default_nettype wire
